// File: logic/msx_alu.sv
/*
  combinational result unit: nibble swap and the two exclusive-or forms.
  assumes operands are stable for the whole execute cycle.
*/
`timescale 1ns/1ns
`include "msx_defs.svh"

module msx_alu (
  input  wire msx_pkg::msx_op_t op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       file_val,
  input  wire logic [7:0]       imm,
  output logic      [7:0]       result,
  output logic                  zero
);

  always_comb begin
    result = `MSX_RST_BYTE;
    unique case (op)
      msx_pkg::MSX_SWAP:    result = {file_val[3:0], file_val[7:4]};
      msx_pkg::MSX_XOR_REG: result = acc ^ file_val;
      msx_pkg::MSX_XOR_IMM: result = acc ^ imm;
      default:              result = `MSX_RST_BYTE;
    endcase
    zero = (result == `MSX_RST_BYTE);
  end

endmodule // msx_alu

// File: logic/msx_defs.svh
/*
  constants for the swap / xor / table-read execution datapath:
  register offsets, field positions, reset values and operation codes.
  assumes it is included by bare name wherever these constants are needed.
*/
`ifndef MSX_DEFS_SVH
`define MSX_DEFS_SVH

// register byte offsets on the apb window
`define MSX_OFF_ACC      12'h000
`define MSX_OFF_STATUS   12'h004
`define MSX_OFF_T0MODE   12'h008
`define MSX_OFF_TPH      12'h00C
`define MSX_OFF_THD      12'h010
`define MSX_OFF_CMD      12'h014
`define MSX_ADDR_W       12

// command word fields
`define MSX_CMD_OP_HI    2
`define MSX_CMD_OP_LO    0
`define MSX_CMD_DEST     7
`define MSX_CMD_FA_HI    14
`define MSX_CMD_FA_LO    8
`define MSX_CMD_IMM_HI   23
`define MSX_CMD_IMM_LO   16

// status fields
`define MSX_ST_ZERO      0
`define MSX_ST_BUSY      1

// operation codes
`define MSX_OP_NOP       3'h0
`define MSX_OP_SWAP      3'h1
`define MSX_OP_XOR_REG   3'h2
`define MSX_OP_XOR_IMM   3'h3
`define MSX_OP_LD_TMODE  3'h4
`define MSX_OP_RD_TMODE  3'h5
`define MSX_OP_TABLE     3'h6

// reset values
`define MSX_RST_BYTE     8'h00
`define MSX_RST_WORD     32'h0000_0000
`define MSX_RST_ZERO     1'b0

// table address: pointer bits above the accumulator byte
`define MSX_TPH_USED_HI  2
`define MSX_PM_ADDR_W    11
`define MSX_PM_DATA_W    14
`define MSX_PM_LO_HI     7
`define MSX_PM_HI_HI     13
`define MSX_PM_HI_LO     8
`define MSX_THD_HI       5

`endif

// File: logic/msx_exec.sv
/*
  execution datapath for nibble swap, exclusive-or, timer-mode moves and
  program-memory table read, with an apb slave holding its registers.
  assumes file register and program memory respond on the same clock:
  file_rdata is combinational from file_addr, pm_rdata is valid in the same
  cycle as pm_rd.
*/
// Functional notes
// - swap exchanges the two nibbles
// - destination bit: zero to accumulator, one to file
// - load mode copies accumulator into timer mode
// - read mode copies timer mode into accumulator
// - table address pointer bits over accumulator; low byte
// - table word bits 13..8 into high data
// - register xor, routed by destination bit
// - immediate xor always to accumulator
`timescale 1ns/1ns
`include "msx_defs.svh"

module msx_exec (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic      [6:0]                  file_addr,
  input  wire logic [7:0]                  file_rdata,
  output logic      [7:0]                  file_wdata,
  output logic                             file_we,
  output logic      [`MSX_PM_ADDR_W-1:0]   pm_addr,
  output logic                             pm_rd,
  input  wire logic [`MSX_PM_DATA_W-1:0]   pm_rdata,
  output logic      [7:0]                  timer0_mode
);

  ////////////////////////////////////////////////////////////////////////
  // state

  msx_pkg::msx_state_t state_q, state_d;
  msx_pkg::msx_op_t    op_q, op_d;
  logic                dest_q, dest_d;
  logic [6:0]          fa_q, fa_d;
  logic [7:0]          imm_q, imm_d;
  logic [7:0]          acc_q, acc_d;
  logic [7:0]          timer0_mode_reg_q, timer0_mode_reg_d;
  logic [7:0]          tph_q, tph_d;
  logic [7:0]          thd_q, thd_d;
  logic                zero_q, zero_d;
  logic [31:0]         cmd_q, cmd_d;
  logic [7:0]          wdata_q, wdata_d;
  logic                we_q, we_d;
  logic [`MSX_PM_ADDR_W-1:0] pma_q, pma_d;
  logic                pmrd_q, pmrd_d;

  logic [7:0]          alu_result;
  logic                alu_zero;
  logic [7:0]          pm_lo;
  logic [5:0]          pm_hi;
  logic                busy;
  logic                acc_en;
  logic                wr_ok;
  logic                mapped;
  logic [`MSX_ADDR_W-1:0] reg_addr;

  assign pm_lo    = pm_rdata[`MSX_PM_LO_HI:0];
  assign pm_hi    = pm_rdata[`MSX_PM_HI_HI:`MSX_PM_HI_LO];
  assign busy     = (state_q != msx_pkg::MSX_IDLE);
  assign reg_addr = paddr[`MSX_ADDR_W-1:0];

  msx_alu u_alu (
    .op       (op_q),
    .acc      (acc_q),
    .file_val (file_rdata),
    .imm      (imm_q),
    .result   (alu_result),
    .zero     (alu_zero)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb slave

  // writes stall while an instruction runs so software never races it
  assign acc_en  = psel && penable;
  assign pready  = !(busy && pwrite);
  assign wr_ok   = acc_en && pwrite && pready;
  assign mapped  = (paddr[31:`MSX_ADDR_W] == '0) && (reg_addr[1:0] == 2'h0) &&
                   (reg_addr <= `MSX_OFF_CMD);
  assign pslverr = acc_en && pready && !mapped;

  always_comb begin
    prdata = `MSX_RST_WORD;
    if (psel && !pwrite) begin
      unique case (reg_addr)
        `MSX_OFF_ACC:    prdata = {24'h000000, acc_q};
        `MSX_OFF_STATUS: prdata = {30'h00000000, busy, zero_q};
        `MSX_OFF_T0MODE: prdata = {24'h000000, timer0_mode_reg_q};
        `MSX_OFF_TPH:    prdata = {24'h000000, tph_q};
        `MSX_OFF_THD:    prdata = {24'h000000, thd_q};
        `MSX_OFF_CMD:    prdata = cmd_q;
        default:         prdata = `MSX_RST_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer and datapath

  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    dest_d  = dest_q;
    fa_d    = fa_q;
    imm_d   = imm_q;
    acc_d   = acc_q;
    timer0_mode_reg_d  = timer0_mode_reg_q;
    tph_d   = tph_q;
    thd_d   = thd_q;
    zero_d  = zero_q;
    cmd_d   = cmd_q;
    wdata_d = wdata_q;
    we_d    = 1'b0;
    pma_d   = pma_q;
    pmrd_d  = 1'b0;
    unique case (state_q)
      msx_pkg::MSX_IDLE: begin
        if (wr_ok) begin
          unique case (reg_addr)
            `MSX_OFF_ACC:    acc_d  = pwdata[7:0];
            `MSX_OFF_STATUS: zero_d = pwdata[`MSX_ST_ZERO];
            `MSX_OFF_TPH:    tph_d  = pwdata[7:0];
            `MSX_OFF_CMD: begin
              cmd_d   = pwdata;
              op_d    = msx_pkg::msx_op_t'(pwdata[`MSX_CMD_OP_HI:`MSX_CMD_OP_LO]);
              dest_d  = pwdata[`MSX_CMD_DEST];
              fa_d    = pwdata[`MSX_CMD_FA_HI:`MSX_CMD_FA_LO];
              imm_d   = pwdata[`MSX_CMD_IMM_HI:`MSX_CMD_IMM_LO];
              state_d = msx_pkg::MSX_EXEC;
            end
            default: ;
          endcase
        end
      end
      msx_pkg::MSX_EXEC: begin
        state_d = msx_pkg::MSX_IDLE;
        unique case (op_q)
          msx_pkg::MSX_SWAP, msx_pkg::MSX_XOR_REG: begin
            if (dest_q) begin
              wdata_d = alu_result;
              we_d    = 1'b1;
            end else begin
              acc_d = alu_result;
            end
            if (op_q == msx_pkg::MSX_XOR_REG) begin
              zero_d = alu_zero;
            end
          end
          msx_pkg::MSX_XOR_IMM: begin
            acc_d  = alu_result;
            zero_d = alu_zero;
          end
          msx_pkg::MSX_LD_TMODE: timer0_mode_reg_d = acc_q;
          msx_pkg::MSX_RD_TMODE: acc_d  = timer0_mode_reg_q;
          msx_pkg::MSX_TABLE: begin
            pma_d   = {tph_q[`MSX_TPH_USED_HI:0], acc_q};
            pmrd_d  = 1'b1;
            state_d = msx_pkg::MSX_TBL_DATA;
          end
          default: ;
        endcase
      end
      msx_pkg::MSX_TBL_DATA: begin
        acc_d   = pm_lo;
        thd_d   = {thd_q[7:6], pm_hi};
        state_d = msx_pkg::MSX_IDLE;
      end
      default: state_d = msx_pkg::MSX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= msx_pkg::MSX_IDLE;
      op_q    <= msx_pkg::MSX_NOP;
      dest_q  <= 1'b0;
      fa_q    <= 7'h00;
      imm_q   <= `MSX_RST_BYTE;
      acc_q   <= `MSX_RST_BYTE;
      timer0_mode_reg_q  <= `MSX_RST_BYTE;
      tph_q   <= `MSX_RST_BYTE;
      thd_q   <= `MSX_RST_BYTE;
      zero_q  <= `MSX_RST_ZERO;
      cmd_q   <= `MSX_RST_WORD;
      wdata_q <= `MSX_RST_BYTE;
      we_q    <= 1'b0;
      pma_q   <= '0;
      pmrd_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      dest_q  <= dest_d;
      fa_q    <= fa_d;
      imm_q   <= imm_d;
      acc_q   <= acc_d;
      timer0_mode_reg_q  <= timer0_mode_reg_d;
      tph_q   <= tph_d;
      thd_q   <= thd_d;
      zero_q  <= zero_d;
      cmd_q   <= cmd_d;
      wdata_q <= wdata_d;
      we_q    <= we_d;
      pma_q   <= pma_d;
      pmrd_q  <= pmrd_d;
    end
  end

  // file write lands one cycle after execute; address is held from the command
  assign file_addr   = fa_q;
  assign file_wdata  = wdata_q;
  assign file_we     = we_q;
  assign pm_addr     = pma_q;
  assign pm_rd       = pmrd_q;
  assign timer0_mode = timer0_mode_reg_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic ex_swap, ex_xr, ex_xi, ex_ld, ex_rd, ex_tbl;
  assign ex_swap = (state_q == msx_pkg::MSX_EXEC) && (op_q == msx_pkg::MSX_SWAP);
  assign ex_xr   = (state_q == msx_pkg::MSX_EXEC) && (op_q == msx_pkg::MSX_XOR_REG);
  assign ex_xi   = (state_q == msx_pkg::MSX_EXEC) && (op_q == msx_pkg::MSX_XOR_IMM);
  assign ex_ld   = (state_q == msx_pkg::MSX_EXEC) && (op_q == msx_pkg::MSX_LD_TMODE);
  assign ex_rd   = (state_q == msx_pkg::MSX_EXEC) && (op_q == msx_pkg::MSX_RD_TMODE);
  assign ex_tbl  = (state_q == msx_pkg::MSX_EXEC) && (op_q == msx_pkg::MSX_TABLE);

  swap_nibbles_a: assert property (@(posedge clk) disable iff (!arst_n)
    ex_swap |=> (dest_q ? (file_we && file_wdata[7:4] == $past(file_rdata[3:0]))
                        : (acc_q[3:0] == $past(file_rdata[7:4]))))
    else $error("swap result wrong");

  dest_route_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ex_swap || ex_xr) && !dest_q |=> !file_we && acc_q == $past(alu_result))
    else $error("destination zero did not reach accumulator");

  tmode_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    ex_ld |=> timer0_mode_reg_q == $past(acc_q) && $stable(acc_q) && state_q == msx_pkg::MSX_IDLE)
    else $error("timer mode load wrong");

  tmode_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    ex_rd |=> acc_q == $past(timer0_mode_reg_q) && $stable(timer0_mode_reg_q))
    else $error("timer mode read wrong");

  table_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
    ex_tbl |=> pm_rd && pm_addr == {$past(tph_q[`MSX_TPH_USED_HI:0]), $past(acc_q)})
    else $error("table address wrong");

  table_data_a: assert property (@(posedge clk) disable iff (!arst_n)
    ex_tbl |=> ##1 acc_q == $past(pm_lo) && thd_q[5:0] == $past(pm_hi))
    else $error("table data not loaded");

  xor_reg_a: assert property (@(posedge clk) disable iff (!arst_n)
    ex_xr && dest_q |=> file_we && file_wdata == ($past(acc_q) ^ $past(file_rdata)))
    else $error("register xor wrong");

  xor_imm_a: assert property (@(posedge clk) disable iff (!arst_n)
    ex_xi |=> !file_we && acc_q == ($past(acc_q) ^ $past(imm_q)))
    else $error("immediate xor wrong");

  zero_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ex_xr || ex_xi) |=> zero_q == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong after xor");

  // instruction cycles only: once idle, software may rewrite the flag
  flags_kept_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ex_swap || ex_ld || ex_rd || ex_tbl || state_q == msx_pkg::MSX_TBL_DATA)
      |=> $stable(zero_q))
    else $error("flag changed by non-xor op");

  cycle_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    ex_tbl |=> state_q == msx_pkg::MSX_TBL_DATA ##1 state_q == msx_pkg::MSX_IDLE)
    else $error("table read not two cycles");

  single_cycle_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ex_swap || ex_xr || ex_xi || ex_ld || ex_rd) |=> state_q == msx_pkg::MSX_IDLE)
    else $error("single cycle op overran");

  write_stall_a: assert property (@(posedge clk) disable iff (!arst_n)
    psel && penable && pwrite && busy |-> !pready)
    else $error("write accepted while busy");

  file_we_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    file_we |=> !file_we)
    else $error("file write longer than one cycle");

  tmode_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(timer0_mode_reg_q) |-> $past(ex_ld))
    else $error("timer mode changed without load");

  pm_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    pm_rd |-> state_q == msx_pkg::MSX_TBL_DATA && !file_we)
    else $error("program read outside table cycle");

endmodule // msx_exec

// File: logic/msx_pkg.sv
/*
  types of the swap / xor / table-read execution datapath.
  assumes msx_defs.svh is on the include path.
*/
`include "msx_defs.svh"

package msx_pkg;

  typedef enum logic [2:0] {
    MSX_NOP      = `MSX_OP_NOP,
    MSX_SWAP     = `MSX_OP_SWAP,
    MSX_XOR_REG  = `MSX_OP_XOR_REG,
    MSX_XOR_IMM  = `MSX_OP_XOR_IMM,
    MSX_LD_TMODE = `MSX_OP_LD_TMODE,
    MSX_RD_TMODE = `MSX_OP_RD_TMODE,
    MSX_TABLE    = `MSX_OP_TABLE
  } msx_op_t;

  typedef enum logic [1:0] {
    MSX_IDLE,
    MSX_EXEC,
    MSX_TBL_DATA
  } msx_state_t;

endpackage

// File: tb/tb_top.sv
/*
  self-checking bench for the swap / xor / table-read datapath:
  random commands over apb, compared with an integer model after each one.
  assumes the bench plays file register (combinational) and program memory.
*/
`timescale 1ns/1ns
`include "msx_defs.svh"

module tb_top;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        file_we, pm_rd, m_z, e, dst, b2b;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [6:0]  file_addr, fa;
  logic [7:0]  file_wdata, timer0_mode;
  logic [7:0]  fmem [128];
  logic [7:0]  mf   [128];
  logic [13:0] pm   [2048];
  logic [10:0] pm_addr, ta;
  logic [7:0]  m_acc, m_tm, m_tph, m_thd, res, fv, imm;
  logic [2:0]  op;
  int          fails, n_tests;
  wire  [7:0]  file_rdata = fmem[file_addr];
  wire  [13:0] pm_rdata   = pm[pm_addr];

  msx_exec DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we),
    .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
    .timer0_mode(timer0_mode));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // file register written back by the design
  always @(posedge clk) begin
    if (file_we === 1'b1) fmem[file_addr] <= file_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request stands until pready is seen high at a rising edge; data and error
  // are taken at that edge; with b2b set the next setup follows at once
  task automatic apb(input logic w, input logic [`MSX_ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] r, output logic er);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {20'h0_0000, a};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    r  = prdata;
    er = pslverr;
    if (k >= 40) fails++;
    if (!b2b) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  initial begin
    #(4 * 30000);
    fails++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    n_tests = 0;
    b2b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    arst_n = 1'b0;
    void'($urandom(24302));
    for (int i = 0; i < 128; i++) begin
      fmem[i] = 8'($urandom);
      mf[i] = fmem[i];
    end
    for (int i = 0; i < 2048; i++) pm[i] = 14'($urandom);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, `MSX_OFF_ACC, 32'h0, rd, e);
    chk(rd, 32'h0000_0000);
    m_acc = 8'($urandom);
    m_tph = 8'($urandom);
    m_tm = 8'h00;
    m_thd = 8'h00;
    m_z = 1'b0;
    apb(1'b1, `MSX_OFF_ACC, {24'h0, m_acc}, rd, e);
    apb(1'b1, `MSX_OFF_TPH, {24'h0, m_tph}, rd, e);
    // read-only mode register must ignore a bus write
    apb(1'b1, `MSX_OFF_T0MODE, 32'h0000_00FF, rd, e);
    apb(1'b0, `MSX_OFF_T0MODE, 32'h0, rd, e);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h018, 32'h0, rd, e);
    chk({31'h0, e}, 32'h0000_0001);
    for (int n = 0; n < 120; n++) begin
      op = 3'($urandom);
      dst = 1'($urandom);
      fa = 7'($urandom);
      imm = 8'($urandom);
      // steer some results to zero so the flag gets set as well as cleared
      if (n % 5 == 0) imm = m_acc;
      if (n % 6 == 0) begin
        fmem[fa] <= m_acc;
        mf[fa] = m_acc;
      end
      if (n % 4 == 3) begin
        m_acc = 8'($urandom);
        apb(1'b1, `MSX_OFF_ACC, {24'h0, m_acc}, rd, e);
        m_z = 1'($urandom);
        apb(1'b1, `MSX_OFF_STATUS, {31'h0, m_z}, rd, e);
      end
      fv = mf[fa];
      b2b = (n % 2 == 1);
      apb(1'b1, `MSX_OFF_CMD, {8'h0, imm, 1'b0, fa, dst, 4'h0, op}, rd, e);
      b2b = 1'b0;
      case (op)
        3'h1: begin
          res = {fv[3:0], fv[7:4]};
          if (dst) mf[fa] = res; else m_acc = res;
        end
        3'h2: begin
          res = m_acc ^ fv;
          m_z = (res == 8'h00);
          if (dst) mf[fa] = res; else m_acc = res;
        end
        3'h3: begin
          m_acc = m_acc ^ imm;
          m_z = (m_acc == 8'h00);
        end
        3'h4: m_tm = m_acc;
        3'h5: m_acc = m_tm;
        3'h6: begin
          ta = {m_tph[2:0], m_acc};
          m_acc = pm[ta][7:0];
          m_thd = {2'b00, pm[ta][13:8]};
        end
        default: ;
      endcase
      // a write right behind the command stalls while a table read runs
      if (n % 2 == 1) begin
        m_tph = 8'($urandom);
        apb(1'b1, `MSX_OFF_TPH, {24'h0, m_tph}, rd, e);
      end
      apb(1'b0, `MSX_OFF_ACC, 32'h0, rd, e);
      chk(rd, {24'h0, m_acc});
      apb(1'b0, `MSX_OFF_STATUS, 32'h0, rd, e);
      chk(rd, {31'h0, m_z});
      chk({24'h0, timer0_mode}, {24'h0, m_tm});
      apb(1'b0, `MSX_OFF_THD, 32'h0, rd, e);
      chk(rd, {24'h0, m_thd});
      chk({24'h0, fmem[fa]}, {24'h0, mf[fa]});
    end
    test_done();
  end
endmodule // tb_top
